//--- hb_port_pkg.sv
// Purpose: shared constants of the half-bridge serial control port
// Assumes: pclk at 10 MHz, serial clock at most 2 MHz
// Notes:   every offset, word, serial lane and irq bit position, control and irq reset value and timing count lives here
package hb_port_pkg;
   // ************************************************************
   // serial word layout
   // ************************************************************
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned BIT_CNT_W  = 5;
   localparam int unsigned CLEAR_BIT  = 0;
   localparam int unsigned SWITCH_LO  = 1;
   localparam int unsigned SWITCH_HI  = 6;
   localparam int unsigned CUTOFF_BIT = 13;
   localparam int unsigned THERM_BIT  = 0;
   localparam int unsigned SHORT_BIT  = 13;
   localparam int unsigned OPEN_BIT   = 14;
   localparam int unsigned SUPPLY_BIT = 15;
   localparam logic [15:0] CTRL_RESET = 16'h2000;
   localparam logic [4:0]  FULL_COUNT = 5'h10;

   // ************************************************************
   // pin synchroniser lanes and their idle levels
   // ************************************************************
   localparam int unsigned PIN_W      = 4;
   localparam int unsigned PIN_SELECT = 0;
   localparam int unsigned PIN_CLK    = 1;
   localparam int unsigned PIN_DATA   = 2;
   localparam int unsigned PIN_RUN    = 3;
   localparam logic [3:0]  PIN_IDLE   = 4'h1;
   localparam logic [3:0]  FAULT_IDLE = 4'h0;

   // ************************************************************
   // register map (byte addresses, 32-bit words)
   // ************************************************************
   localparam logic [7:0]  ADDR_CONTROL = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_STS = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_MSK = 8'h0C;
   localparam int unsigned IRQ_W        = 4;
   localparam int unsigned IRQ_FRAME    = 0;
   localparam int unsigned IRQ_LENGTH   = 1;
   localparam int unsigned IRQ_FAULT    = 2;
   localparam int unsigned IRQ_FAST     = 3;
   localparam logic [3:0]  IRQ_RESET    = 4'h0;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned PCLK_PERIOD_NS     = 100;
   localparam int unsigned SCLK_MIN_PERIOD_NS = 500;
   localparam int unsigned SCLK_MIN_CYCLES    =
      (SCLK_MIN_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam logic [3:0]  GAP_MIN = 4'(SCLK_MIN_CYCLES);
   localparam logic [3:0]  GAP_MAX = 4'hF;

   typedef enum logic [0:0] {
      LINK_IDLE  = 1'b0,
      LINK_SHIFT = 1'b1
   } link_mode_t;
endpackage

//--- frame_link_if.sv
// Purpose: carries synchronised pin levels and frame results between core and shifter
// Assumes: all signals on pclk
// Notes:   pulses last one pclk cycle
`timescale 1ns/1ps
`default_nettype none
interface frame_link_if;
   logic        select_n;
   logic        sclk;
   logic        din;
   logic        active;
   logic [15:0] status_word;
   logic [15:0] rx_word;
   logic        frame_done;
   logic        length_err;
   logic        too_fast;
   logic        serial_out;
   logic        serial_out_en;

   modport core (output select_n, sclk, din, active, status_word,
                 input rx_word, frame_done, length_err, too_fast, serial_out, serial_out_en);
   modport shifter (input select_n, sclk, din, active, status_word,
                    output rx_word, frame_done, length_err, too_fast, serial_out, serial_out_en);
endinterface
`default_nettype wire

//--- pin_sync.sv
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: inputs change freely with respect to pclk
// Notes:   reset value stands in for the pin's idle (pulled) level
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned W          = 4,
   parameter logic [W-1:0] IDLE_LEVEL = '0
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // ************************************************************
   // per-lane chain; only the second flop is seen outside
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         always_comb begin
            next_state.first[i]  = pin[i];
            next_state.second[i] = state.first[i];
         end
      end
   endgenerate

   // undriven select reads deselected, other pins read low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= {IDLE_LEVEL, IDLE_LEVEL};
      end else begin
         state <= next_state;
      end
   end

   assign level = state.second;
endmodule
`default_nettype wire

//--- frame_shifter.sv
// Purpose: serial frame engine, sampled on pclk
// Assumes: pin levels already synchronised
// Notes:   edges are found by comparing each synchronised level with its delay
`timescale 1ns/1ps
`default_nettype none
module frame_shifter
   import hb_port_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   frame_link_if.shifter link
);
   typedef struct packed {
      link_mode_t           mode;
      logic                 clk_d;
      logic                 sel_d;
      logic [BIT_CNT_W-1:0] count;
      logic [3:0]           gap;
      logic [WORD_W-1:0]    rx;
      logic [WORD_W-1:0]    tx;
      logic [WORD_W-1:0]    word;
      logic                 out_en;
      logic                 done;
      logic                 len_err;
      logic                 fast;
   } shift_state_t;

   shift_state_t state;
   shift_state_t next_state;
   logic         clk_rise;
   logic         clk_fall;
   logic         sel_fall;
   logic         sel_rise;

   // ************************************************************
   // edge detect and frame sequence
   // ************************************************************
   assign clk_rise = link.sclk & ~state.clk_d;
   assign clk_fall = ~link.sclk & state.clk_d;
   assign sel_fall = ~link.select_n & state.sel_d;
   assign sel_rise = link.select_n & ~state.sel_d;

   always_comb begin
      next_state         = state;
      next_state.clk_d   = link.sclk;
      next_state.sel_d   = link.select_n;
      next_state.done    = 1'b0;
      next_state.len_err = 1'b0;
      next_state.fast    = 1'b0;
      if (state.gap != GAP_MAX) begin
         next_state.gap = state.gap + 4'h1;
      end
      if (!link.active) begin
         next_state.mode   = LINK_IDLE;
         next_state.out_en = 1'b0;
      end else begin
         unique case (state.mode)
            LINK_IDLE: begin
               if (sel_fall) begin
                  next_state.mode   = LINK_SHIFT;
                  next_state.out_en = 1'b1;
                  next_state.tx     = link.status_word;
                  next_state.count  = '0;
                  next_state.gap    = GAP_MAX;
               end
            end
            LINK_SHIFT: begin
               // lsb arrives first, so it ends at bit 0 after sixteen bits
               if (clk_fall) begin
                  next_state.rx  = {link.din, state.rx[WORD_W-1:1]};
                  next_state.gap = 4'h1;
                  next_state.fast = (state.gap < GAP_MIN);
                  if (state.count != 5'h1F) begin
                     next_state.count = state.count + 5'h01;
                  end
               end
               // bit 0 is presented from select fall through the first rise
               if (clk_rise && state.count != '0) begin
                  next_state.tx = {1'b0, state.tx[WORD_W-1:1]};
               end
               if (sel_rise) begin
                  next_state.mode    = LINK_IDLE;
                  next_state.out_en  = 1'b0;
                  next_state.word    = state.rx;
                  next_state.done    = 1'b1;
                  next_state.len_err = (state.count != FULL_COUNT);
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{mode: LINK_IDLE, clk_d: 1'b0, sel_d: 1'b1, count: '0, gap: GAP_MAX,
                    rx: '0, tx: '0, word: CTRL_RESET, out_en: 1'b0, done: 1'b0,
                    len_err: 1'b0, fast: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign link.rx_word       = state.word;
   assign link.frame_done    = state.done;
   assign link.length_err    = state.len_err;
   assign link.too_fast      = state.fast;
   assign link.serial_out    = state.tx[0];
   assign link.serial_out_en = state.out_en;
endmodule
`default_nettype wire

//--- half_bridge_serial_control_port.sv
// Purpose: serial control and status port of a triple half-bridge driver, with APB view
// Assumes: pclk 10 MHz; serial clock, select, data and fault inputs are asynchronous
// Notes:   serial clock is oversampled, so it must stay at or under 2 MHz
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_serial_control_port
   import hb_port_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        select_n,
   input  wire logic        sclk,
   input  wire logic        serial_in,
   input  wire logic        standby_control,
   output logic             serial_out,
   output logic             serial_out_en,
   input  wire logic        thermal_warning,
   input  wire logic        short_detect,
   input  wire logic        open_load_detect,
   input  wire logic        supply_low_detect,
   output logic             low_switch_1,
   output logic             high_switch_1,
   output logic             low_switch_2,
   output logic             high_switch_2,
   output logic             low_switch_3,
   output logic             high_switch_3,
   output logic             irq
);
   typedef struct packed {
      logic [WORD_W-1:0] ctrl;
      logic              short_flag;
      logic              open_load_flag;
      logic              supply_fail_flag;
      logic              thermal;
      logic [IRQ_W-1:0]  irq_status;
      logic [IRQ_W-1:0]  irq_mask;
   } core_state_t;

   core_state_t state;
   core_state_t next_state;
   frame_link_if link ();

   logic [PIN_W-1:0] pins;
   logic [3:0]       faults;
   logic [5:0]       switches;
   logic [15:0]      status_word;
   logic [IRQ_W-1:0] events;
   logic             active;
   logic             wr_en;
   logic             rd_en;
   logic             clr_req;
   logic             cut_off;
   logic             short_set;
   logic             open_set;
   logic             supply_set;

   // ************************************************************
   // address decode, shared by the read path and the error response
   // ************************************************************
   function automatic logic addr_hit(input logic [7:0] addr);
      return (addr == ADDR_CONTROL) || (addr == ADDR_STATUS) ||
             (addr == ADDR_IRQ_STS) || (addr == ADDR_IRQ_MSK);
   endfunction

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // idle select is high so an open select pin reads deselected
   pin_sync #(
      .W          (PIN_W),
      .IDLE_LEVEL (PIN_IDLE)
   ) u_serial_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     ({standby_control, serial_in, sclk, select_n}),
      .level   (pins)
   );

   pin_sync #(
      .W          (4),
      .IDLE_LEVEL (FAULT_IDLE)
   ) u_fault_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     ({supply_low_detect, open_load_detect, short_detect, thermal_warning}),
      .level   (faults)
   );

   // ************************************************************
   // frame engine
   // ************************************************************
   assign active = pins[PIN_RUN];

   assign link.select_n    = pins[PIN_SELECT];
   assign link.sclk        = pins[PIN_CLK];
   assign link.din         = pins[PIN_DATA];
   assign link.active      = active;
   assign link.status_word = status_word;

   frame_shifter u_shifter (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link.shifter)
   );

   // the pin only carries data while selected and awake
   assign serial_out    = link.serial_out;
   assign serial_out_en = link.serial_out_en;

   // ************************************************************
   // switch outputs and status word
   // ************************************************************
   // standby forces every switch off whatever the control word says
   assign switches = active ? state.ctrl[SWITCH_HI:SWITCH_LO] : 6'h00;

   assign low_switch_1  = switches[0];
   assign high_switch_1 = switches[1];
   assign low_switch_2  = switches[2];
   assign high_switch_2 = switches[3];
   assign low_switch_3  = switches[4];
   assign high_switch_3 = switches[5];

   // unused positions read as zero
   always_comb begin
      status_word                        = 16'h0000;
      status_word[THERM_BIT]             = state.thermal;
      status_word[SWITCH_HI:SWITCH_LO]   = switches;
      status_word[SHORT_BIT]             = state.short_flag;
      status_word[OPEN_BIT]              = state.open_load_flag;
      status_word[SUPPLY_BIT]            = state.supply_fail_flag;
   end

   // ************************************************************
   // fault flags and control word
   // ************************************************************
   assign clr_req    = link.frame_done & link.rx_word[CLEAR_BIT];
   assign short_set  = faults[1] & active;
   assign open_set   = faults[2] & active;
   assign supply_set = faults[3] & active;
   // cutoff acts on the word that will stand after this cycle
   assign cut_off    = short_set & (link.frame_done ? link.rx_word[CUTOFF_BIT]
                                                    : state.ctrl[CUTOFF_BIT]);

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~pwrite;

   // ************************************************************
   // interrupt events
   // ************************************************************
   always_comb begin
      events             = '0;
      events[IRQ_FRAME]  = link.frame_done;
      events[IRQ_LENGTH] = link.length_err;
      events[IRQ_FAULT]  = (short_set & ~state.short_flag) |
                           (open_set & ~state.open_load_flag) |
                           (supply_set & ~state.supply_fail_flag);
      events[IRQ_FAST]   = link.too_fast;
   end

   always_comb begin
      next_state         = state;
      next_state.thermal = faults[0] & active;

      // a word takes effect only when select rises
      if (link.frame_done) begin
         next_state.ctrl = link.rx_word;
      end
      if (cut_off) begin
         next_state.ctrl[SWITCH_HI:SWITCH_LO] = 6'h00;
      end
      // standby returns the control word to its power-on value
      if (!active) begin
         next_state.ctrl = CTRL_RESET;
      end

      // a fault seen in the clearing cycle survives the clear
      next_state.short_flag       = (state.short_flag & ~clr_req) | short_set;
      next_state.open_load_flag   = (state.open_load_flag & ~clr_req) | open_set;
      next_state.supply_fail_flag = (state.supply_fail_flag & ~clr_req) | supply_set;

      // write-one-to-clear, new events win over the clear
      next_state.irq_status = state.irq_status;
      if (wr_en && paddr == ADDR_IRQ_STS) begin
         next_state.irq_status = state.irq_status & ~pwdata[IRQ_W-1:0];
      end
      next_state.irq_status = next_state.irq_status | events;

      if (wr_en && paddr == ADDR_IRQ_MSK) begin
         next_state.irq_mask = pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{ctrl: CTRL_RESET, short_flag: 1'b0, open_load_flag: 1'b0,
                    supply_fail_flag: 1'b0, thermal: 1'b0, irq_status: IRQ_RESET,
                    irq_mask: IRQ_RESET};
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // apb slave
   // ************************************************************
   // zero wait states keep the slave simple; every access completes at once
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_hit(paddr);

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en && addr_hit(paddr)) begin
         unique case (paddr)
            ADDR_CONTROL: prdata = {16'h0000, state.ctrl};
            ADDR_STATUS:  prdata = {16'h0000, status_word};
            ADDR_IRQ_STS: prdata = {28'h0000000, state.irq_status};
            ADDR_IRQ_MSK: prdata = {28'h0000000, state.irq_mask};
            default:      prdata = 32'h0000_0000;
         endcase
      end
   end

   // level output, high while any unmasked event is pending
   assign irq = |(state.irq_status & state.irq_mask);
endmodule
`default_nettype wire

//--- hb_port_assertions.sv
// Purpose: concurrent checks on the serial control port pins
// Assumes: pins seen about three pclk after they move
// Notes:   windows are a little wider than the sync delay
`timescale 1ns/1ps
`default_nettype none
module hb_port_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        select_n,
   input wire logic        sclk,
   input wire logic        standby_control,
   input wire logic        short_detect,
   input wire logic        serial_out,
   input wire logic        serial_out_en,
   input wire logic [5:0]  sw,
   input wire logic        irq
);
   logic [4:0] sclk_d;
   logic       rose_seen;
   // ****
   // sclk history, so a data change can be tied to a recent rise
   // ****
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d <= '0;
      end else begin
         sclk_d <= {sclk_d[3:0], sclk};
      end
   end
   assign rose_seen = |(sclk_d[3:0] & ~sclk_d[4:1]);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   bit_hold_a: assert property (serial_out_en && $past(serial_out_en) && $changed(serial_out)
      |-> rose_seen) else $error("data out moved without a clock rise");
   out_float_a: assert property (select_n [*5] |-> !serial_out_en)
      else $error("data out driven while deselected");
   drive_start_a: assert property (($fell(select_n) && standby_control)
      ##1 (!select_n && standby_control) [*4] |-> serial_out_en)
      else $error("data out not driven after select fall");
   switch_hold_a: assert property ((!select_n && standby_control && !short_detect) [*6]
      |-> $stable(sw)) else $error("switches moved inside a frame");
   standby_off_a: assert property ((!standby_control) [*5]
      |-> (sw == 6'h00 && !serial_out_en)) else $error("active during standby");
   ready_high_a: assert property (psel |-> pready) else $error("wait state inserted");
   bad_addr_a: assert property ((psel && penable && paddr > 8'h0C) |-> pslverr)
      else $error("unmapped access without error");
   idle_data_a: assert property (!psel |-> (prdata == 32'h0 && !pslverr))
      else $error("bus outputs busy while idle");
   cover property ($rose(serial_out_en));
   cover property ($changed(sw));
   cover property ($rose(irq));
endmodule
bind half_bridge_serial_control_port hb_port_checker u_hb_port_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .select_n(select_n),
   .sclk(sclk), .standby_control(standby_control), .short_detect(short_detect),
   .serial_out(serial_out), .serial_out_en(serial_out_en), .irq(irq),
   .sw({high_switch_3, low_switch_3, high_switch_2, low_switch_2, high_switch_1, low_switch_1}));
`default_nettype wire

//--- host_model.sv
// Purpose: host serial master for the control port
// Assumes: 800 ns sclk period, sclk idle low
// Notes:   released data line shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module host_model (
   output logic      select_n,
   output logic      sclk,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_en
);
   logic last_bit = 1'b0;
   logic line;
   // quarter of an sclk period; 200 gives the 800 ns bench clock, under 125 breaks the limit
   int   step = 200;
   initial select_n = 1'b1;
   initial sclk = 1'b0;
   initial serial_in = 1'b0;
   // a floating line must not look like valid data
   assign line = serial_out_en ? serial_out : ~last_bit;
   always @(serial_out) if (serial_out_en) last_bit = serial_out;
   // ****
   // one frame: data set mid-low, device samples at fall, host reads before rise
   // ****
   task automatic frame(input logic [15:0] word, input int n, output logic [15:0] got);
      got = '0;
      // pin edges stay off the pclk edge, so the synchronisers never race the host
      #25;
      select_n = 1'b0;
      #400;
      for (int i = 0; i <= n; i++) begin
         #step;
         if (i < n) serial_in = word[i];
         #step;
         if (i > 0) got[i-1] = line;
         if (i < n) begin
            sclk = 1'b1;
            #(2 * step);
            sclk = 1'b0;
         end
      end
      select_n = 1'b1;
      serial_in = 1'b0;
      #775;
   endtask
endmodule
`default_nettype wire

//--- half_bridge_serial_control_port_tb.sv
// Purpose: self-checking bench for the serial control port
// Assumes: pclk 100 ns, host model for the serial side
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module half_bridge_serial_control_port_tb
   import hb_port_pkg::*;
();
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        select_n;
   logic        sclk;
   logic        serial_in;
   logic        standby_control = 1'b1;
   logic        serial_out;
   logic        serial_out_en;
   logic        thermal_warning = 1'b0;
   logic        short_detect = 1'b0;
   logic        open_load_detect = 1'b0;
   logic        supply_low_detect = 1'b0;
   wire  [5:0]  sw;
   logic        irq;
   logic [15:0] got;
   int          n_errors = 0;
   int          tests_run = 0;
   always #50 pclk = ~pclk;
   half_bridge_serial_control_port u_half_bridge_serial_control_port (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
      .standby_control(standby_control), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .thermal_warning(thermal_warning),
      .short_detect(short_detect), .open_load_detect(open_load_detect),
      .supply_low_detect(supply_low_detect), .low_switch_1(sw[0]), .high_switch_1(sw[1]),
      .low_switch_2(sw[2]), .high_switch_2(sw[3]), .low_switch_3(sw[4]),
      .high_switch_3(sw[5]), .irq(irq));
   host_model u_host_model (.select_n(select_n), .sclk(sclk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_en(serial_out_en));
   // ****
   // shared helpers
   // ****
   task automatic check(input logic [31:0] g, input logic [31:0] exp);
      tests_run++;
      if (g !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
         close_out();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      repeat (3) @(posedge pclk);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      rd(ADDR_CONTROL, {16'h0, CTRL_RESET});
      rd(ADDR_IRQ_MSK, 32'h0);
      check({26'h0, sw}, 32'h0);
      wr(ADDR_CONTROL, 32'h0000_FFFF);
      rd(ADDR_CONTROL, 32'h2000);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_frame;
      @(posedge pclk);
      thermal_warning <= 1'b1;
      repeat (5) @(posedge pclk);
      u_host_model.frame(16'h207E, 16, got);
      check({16'h0, got}, 32'h0001);
      check({26'h0, sw}, 32'h3F);
      rd(ADDR_CONTROL, 32'h207E);
      u_host_model.frame(16'h2014, 16, got);
      check({16'h0, got}, 32'h007F);
      check({26'h0, sw}, 32'h0A);
      thermal_warning <= 1'b0;
      rd(ADDR_IRQ_STS, 32'h1);
      wr(ADDR_IRQ_MSK, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_STS, 32'h1);
      check({31'h0, irq}, 32'h0);
      $display("frame test done");
   endtask
   task automatic t_fault;
      wr(ADDR_IRQ_MSK, 32'h4);
      open_load_detect <= 1'b1;
      supply_low_detect <= 1'b1;
      repeat (6) @(posedge pclk);
      open_load_detect <= 1'b0;
      supply_low_detect <= 1'b0;
      repeat (4) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      rd(ADDR_STATUS, 32'hC014);
      short_detect <= 1'b1;
      repeat (6) @(posedge pclk);
      short_detect <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(ADDR_STATUS, 32'hE000);
      wr(ADDR_IRQ_STS, 32'h4);
      check({31'h0, irq}, 32'h0);
      u_host_model.frame(16'h2003, 16, got);
      check({16'h0, got}, 32'hE000);
      rd(ADDR_STATUS, 32'h0002);
      $display("fault test done");
   endtask
   task automatic t_length;
      wr(ADDR_IRQ_STS, 32'hF);
      u_host_model.frame(16'h0000, 12, got);
      rd(ADDR_IRQ_STS, 32'h3);
      // a 400 ns sclk breaks the host limit and must raise the fast flag
      wr(ADDR_IRQ_STS, 32'hF);
      u_host_model.step = 100;
      u_host_model.frame(16'h0000, 16, got);
      u_host_model.step = 200;
      rd(ADDR_IRQ_STS, 32'h9);
      $display("length test done");
   endtask
   task automatic t_standby;
      standby_control <= 1'b0;
      repeat (6) @(posedge pclk);
      check({26'h0, sw}, 32'h0);
      rd(ADDR_CONTROL, 32'h2000);
      u_host_model.frame(16'h207E, 16, got);
      check({26'h0, sw}, 32'h0);
      rd(ADDR_CONTROL, 32'h2000);
      standby_control <= 1'b1;
      repeat (6) @(posedge pclk);
      $display("standby test done");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog: a 16-bit frame at the 800 ns bench clock takes about 15 us, the whole run well under 1 ms
   initial begin
      #2_000_000;
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_reset();
      t_frame();
      t_fault();
      t_length();
      t_standby();
      close_out();
   end
endmodule
`default_nettype wire
